// *** csdr_pkg.sv ***
// constants, field layouts and types for the channel sequence delay registers
// assumes an 8-bit register port and a sequencer that supplies triggers
package csdr_pkg;
	localparam logic [7:0] ADDR_CH56_ON = 8'h06;
	localparam logic [7:0] ADDR_CH7_ON = 8'h07;
	localparam logic [7:0] ADDR_CH12_OFF = 8'h08;
	localparam logic [7:0] ADDR_SCALE = 8'h23;
	localparam int LO_POS = 0;
	localparam int HI_POS = 4;
	localparam int EXT_POS = 2;
	localparam int CODE_W = 3;
	localparam int CLOCK_HZ = 200000000;
	localparam int MS_PER_S = 1000;
	localparam int TICK_CYCLES = CLOCK_HZ / MS_PER_S;
	localparam int TICK_W = 18;
	localparam int ON_STEP_MS = 2;
	localparam int OFF_STEP_MS = 4;
	localparam int EXT_STEP_MS = 16;
	localparam int MS_W = 7;
	localparam int NCH = 5;
	// channel index: 0=ch5 on,1=ch6 on,2=ch7 on,3=ch1 off,4=ch2 off
	typedef struct packed {
		logic [CODE_W-1:0] ch5On;
		logic [CODE_W-1:0] ch6On;
		logic [CODE_W-1:0] ch7On;
		logic [CODE_W-1:0] ch1Off;
		logic [CODE_W-1:0] ch2Off;
		logic scaleX4;
	} csdr_fuse_t;
	typedef enum logic [1:0] {
		CSDR_IDLE = 2'b00,
		CSDR_COUNT = 2'b01,
		CSDR_DONE = 2'b10
	} csdr_state_t;
endpackage

// *** csdr_delay_regs.sv ***
// register file and delay timers for ch5-7 turn-on and ch1-2 turn-off
// assumes synchronous register port strobes and single-cycle triggers
`timescale 1ns/1ps
module csdr_delay_regs
(
	input wire logic clock,
	input wire logic rst_b,
	input wire csdr_pkg::csdr_fuse_t fuse,
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic [csdr_pkg::NCH-1:0] seqTrigger,
	output logic [csdr_pkg::NCH-1:0] delayDone,
	output logic [csdr_pkg::NCH*csdr_pkg::MS_W-1:0] delayMs
);
	import csdr_pkg::*;

	logic [CODE_W-1:0] ch5OnDelayCode;
	logic [CODE_W-1:0] ch6OnDelayCode;
	logic [CODE_W-1:0] ch7OnDelayCode;
	logic [CODE_W-1:0] ch1OffDelayCode;
	logic [CODE_W-1:0] ch2OffDelayCode;
	logic offDelayScaleX4;
	logic [TICK_W-1:0] tickCount;
	logic msTick;
	logic [CODE_W-1:0] codes [NCH];
	logic [3:0] sel;

	function automatic logic [MS_W-1:0] toMs(input logic [CODE_W-1:0] c,
		input int step);
		toMs = MS_W'(int'(c) * step);
	endfunction

	// one-hot register select, shared by the write and the read path so
	// that both always agree on which addresses are mapped
	function automatic logic [3:0] regSelect(input logic [7:0] a);
		regSelect = 4'h0;
		if (a == ADDR_CH56_ON)
			regSelect[0] = 1'b1;
		else if (a == ADDR_CH7_ON)
			regSelect[1] = 1'b1;
		else if (a == ADDR_CH12_OFF)
			regSelect[2] = 1'b1;
		else if (a == ADDR_SCALE)
			regSelect[3] = 1'b1;
	endfunction

	assign sel = regSelect(regAddr);

	// fuse values load on every reset, so no fixed constant appears here
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			ch5OnDelayCode <= fuse.ch5On;
			ch6OnDelayCode <= fuse.ch6On;
		end
		else if (regWrite && sel[0])
		begin
			ch6OnDelayCode <= regWdata[HI_POS +: CODE_W];
			ch5OnDelayCode <= regWdata[LO_POS +: CODE_W];
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			ch7OnDelayCode <= fuse.ch7On;
		else if (regWrite && sel[1])
			ch7OnDelayCode <= regWdata[LO_POS +: CODE_W];
	end

	// off-delay codes; a write while a timer runs moves its target live
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			ch1OffDelayCode <= fuse.ch1Off;
			ch2OffDelayCode <= fuse.ch2Off;
		end
		else if (regWrite && sel[2])
		begin
			ch2OffDelayCode <= regWdata[HI_POS +: CODE_W];
			ch1OffDelayCode <= regWdata[LO_POS +: CODE_W];
		end
	end

	// only the extend bit of this address lives here; the rest is ignored
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			offDelayScaleX4 <= fuse.scaleX4;
		else if (regWrite && sel[3])
			offDelayScaleX4 <= regWdata[EXT_POS];
	end

	// unassigned bits read zero; unmapped addresses read zero
	// read data is combinational so a read needs no wait cycle
	always_comb
	begin
		regRdata = 8'h00;
		if (sel[0])
		begin
			regRdata[HI_POS +: CODE_W] = ch6OnDelayCode;
			regRdata[LO_POS +: CODE_W] = ch5OnDelayCode;
		end
		else if (sel[1])
			regRdata[LO_POS +: CODE_W] = ch7OnDelayCode;
		else if (sel[2])
		begin
			regRdata[HI_POS +: CODE_W] = ch2OffDelayCode;
			regRdata[LO_POS +: CODE_W] = ch1OffDelayCode;
		end
		else if (sel[3])
			regRdata[EXT_POS] = offDelayScaleX4;
	end

	// free-running millisecond enable shared by all timers
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			tickCount <= '0;
		else if (tickCount == TICK_W'(TICK_CYCLES - 1))
			tickCount <= '0;
		else
			tickCount <= tickCount + 1'b1;
	end
	assign msTick = (tickCount == TICK_W'(TICK_CYCLES - 1));

	assign codes[0] = ch5OnDelayCode;
	assign codes[1] = ch6OnDelayCode;
	assign codes[2] = ch7OnDelayCode;
	assign codes[3] = ch1OffDelayCode;
	assign codes[4] = ch2OffDelayCode;

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : gTimer
			logic [MS_W-1:0] target;
			logic [MS_W-1:0] elapsed;
			logic [MS_W-1:0] next_elapsed;
			csdr_state_t state;
			csdr_state_t next_state;
			// turn-on 2 ms steps; turn-off 4 or 16 ms per extend bit
			if (g < 3)
			begin : gOn
				assign target = toMs(codes[g], ON_STEP_MS);
			end
			else
			begin : gOff
				assign target = offDelayScaleX4 ?
					toMs(codes[g], EXT_STEP_MS) :
					toMs(codes[g], OFF_STEP_MS);
			end
			assign delayMs[g*MS_W +: MS_W] = target;
			assign delayDone[g] = (state == CSDR_DONE);
			// a trigger wins over the running count, so a retrigger
			// restarts the delay from zero instead of ending the old one
			// the first partial tick is counted as whole: up to 1 ms early
			always_comb
			begin
				next_state = state;
				next_elapsed = elapsed;
				if (seqTrigger[g])
				begin
					next_elapsed = '0;
					next_state = (target == '0) ? CSDR_DONE : CSDR_COUNT;
				end
				else
				begin
					case (state)
						CSDR_IDLE:
							next_state = CSDR_IDLE;
						CSDR_COUNT:
						begin
							if (msTick)
							begin
								next_elapsed = elapsed + 1'b1;
								// >= so a target lowered mid-count still ends
								if (elapsed + 1'b1 >= target)
									next_state = CSDR_DONE;
							end
						end
						CSDR_DONE:
							next_state = CSDR_IDLE;
						default:
							next_state = CSDR_IDLE;
					endcase
				end
			end

			always_ff @(posedge clock)
			begin
				if (!rst_b)
					state <= CSDR_IDLE;
				else
					state <= next_state;
			end

			always_ff @(posedge clock)
			begin
				if (!rst_b)
					elapsed <= '0;
				else
					elapsed <= next_elapsed;
			end
		end
	endgenerate
endmodule

// *** csdr_delay_regs_asserts.sv ***
// concurrent checks on register readback, delay values and timer pulses
// assumes a bind onto csdr_delay_regs with ports of the same names
`timescale 1ns/1ps
module csdr_delay_regs_asserts
(
	input wire logic clock,
	input wire logic rst_b,
	input wire csdr_pkg::csdr_fuse_t fuse,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regRdata,
	input wire logic [4:0] seqTrigger,
	input wire logic [4:0] delayDone,
	input wire logic [34:0] delayMs
);
	import csdr_pkg::*;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	property p_ch6;
		regAddr==8'h06 |-> delayMs[13:7]==2*regRdata[6:4];
	endproperty
	a_ch6: assert property (p_ch6) else $error("ch6 on delay");
	property p_ch5;
		regAddr==8'h06 |-> delayMs[6:0]==2*regRdata[2:0];
	endproperty
	a_ch5: assert property (p_ch5) else $error("ch5 on delay");
	property p_ch7;
		regAddr==8'h07 |-> !regRdata[7:3] && delayMs[20:14]==2*regRdata[2:0];
	endproperty
	a_ch7: assert property (p_ch7) else $error("ch7 on delay");
	property p_fuse;
		$rose(rst_b) && regAddr==8'h06
		|-> regRdata=={1'b0,fuse.ch6On,1'b0,fuse.ch5On};
	endproperty
	a_fuse: assert property (p_fuse) else $error("fuse load");
	// either table is legal here; the ratio check ties both fields to one
	property p_ch1;
		regAddr==8'h08 |-> delayMs[27:21]==4*regRdata[2:0]
		|| delayMs[27:21]==16*regRdata[2:0];
	endproperty
	a_ch1: assert property (p_ch1) else $error("ch1 off delay");
	property p_ch2;
		regAddr==8'h08 |->
		delayMs[34:28]*regRdata[2:0]==delayMs[27:21]*regRdata[6:4];
	endproperty
	a_ch2: assert property (p_ch2) else $error("ch2 off delay");
	property p_ext;
		regAddr==8'h23 |-> !(regRdata&8'hfb);
	endproperty
	a_ext: assert property (p_ext) else $error("extend reg");
	property p_zero;
		seqTrigger[0] && !delayMs[6:0] |=> delayDone[0];
	endproperty
	a_zero: assert property (p_zero) else $error("zero delay");
	c_all: cover property (delayDone==5'h1f);
	c_ext: cover property (regAddr==8'h23 && regRdata[2]);
	c_rst: cover property ($rose(rst_b));
endmodule

// *** csdr_delay_regs_tb.sv ***
// self-checking bench for the channel delay registers and timers
// assumes the design's package is compiled first
`timescale 1ns/1ps
module csdr_delay_regs_tb;
	import csdr_pkg::*;
	logic clock=0, rst_b=0, regWrite=0;
	logic [7:0] regAddr=8'h08, regWdata=0, regRdata;
	logic [4:0] seqTrigger=0, delayDone;
	logic [34:0] delayMs;
	logic [31:0] s=32'h09d6;
	csdr_fuse_t fuse=16'h0;
	logic [7:0] m [4];
	logic [7:0] f [4];
	logic [7:0] A [4]='{8'h06,8'h07,8'h08,8'h23};
	logic [7:0] M [4]='{8'h77,8'h07,8'h77,8'h04};
	int miscompares=0, comparisons=0;
	csdr_delay_regs DUT (.*);
	initial
	begin
		forever #2.5 clock=~clock;
	end
	function logic [31:0] lf(logic [31:0] v);
		return {v[30:0],v[31]^v[21]^v[1]^v[0]};
	endfunction
	function logic [34:0] dm();
		int k;
		k=m[3][2]?16:4;
		return {7'(m[2][6:4]*k),7'(m[2][2:0]*k),7'(m[1][2:0]*2),
			7'(m[0][6:4]*2),7'(m[0][2:0]*2)};
	endfunction
	task cmp(string n, logic [34:0] e, logic [34:0] g);
		comparisons++;
		if (e!==g)
		begin
			$display("[ERR] %s exp %h got %h",n,e,g);
			miscompares++;
		end
	endtask
	task wr(logic [7:0] a, logic [7:0] d);
		@(negedge clock);
		regAddr=a;
		regWdata=d;
		regWrite=1;
		@(negedge clock);
		regWrite=0;
	endtask
	task chk(int i);
		regAddr=A[i];
		#1;
		cmp("reg",35'(regRdata),35'(m[i]));
		cmp("delayMs",dm(),delayMs);
	endtask
	task close_out;
		$display("checks %0d errors %0d",comparisons,miscompares);
		if (miscompares==0 && comparisons>0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		s=lf(s);
		fuse=s[15:0];
		m='{{1'b0,fuse.ch6On,1'b0,fuse.ch5On},{5'h0,fuse.ch7On},
			{1'b0,fuse.ch2Off,1'b0,fuse.ch1Off},{5'h0,fuse.scaleX4,2'b0}};
		f=m;
		repeat(12) @(negedge clock);
		rst_b=1;
		for (int i=0; i<4; i++) chk(i);
		$display("fuse load test done");
		repeat(8)
		begin
			for (int i=0; i<4; i++)
			begin
				s=lf(s);
				wr(A[i],s[7:0]);
				m[i]=s[7:0]&M[i];
			end
			for (int i=0; i<4; i++) chk(i);
		end
		$display("random write test done");
		@(negedge clock);
		rst_b=0;
		repeat(2) @(negedge clock);
		rst_b=1;
		m=f;
		for (int i=0; i<4; i++) chk(i);
		$display("mid-run reset test done");
		wr(8'h40,8'hff);
		#1;
		cmp("unmapped",35'(regRdata),35'h0);
		for (int i=0; i<3; i++) wr(A[i],8'h00);
		seqTrigger=5'h1f;
		@(negedge clock);
		cmp("delayDone",35'(delayDone),35'h1f);
		seqTrigger=0;
		@(negedge clock);
		cmp("delayDone",35'(delayDone),35'h0);
		$display("zero delay test done");
		close_out;
	end
	initial
	begin
		#100000;
		miscompares++;
		close_out;
	end
endmodule
bind csdr_delay_regs csdr_delay_regs_asserts u_chk (.*);
